// File: hdl/smii_pkg.sv
// Shared constants for the serial media-independent port block
package smii_pkg;
  localparam int          SEG_BITS    = 10;        // Bits in one segment
  localparam int          CNT_W       = 4;         // Width of bit counters
  localparam logic [3:0]  BIT_FIRST   = 4'h0;      // Counter at first bit
  localparam logic [3:0]  BIT_SECOND  = 4'h1;      // Counter after first bit
  localparam logic [3:0]  BIT_LAST    = 4'h9;      // Counter at tenth bit
  localparam logic [3:0]  CNT_RST     = 4'h0;      // Receive counter after a load
  localparam logic [3:0]  SS_CNT_RST  = 4'h9;      // First launch loads
  localparam int          SYNC_STAGES = 3;         // Flops on a pin input
  localparam logic        MDIO_IDLE   = 1'b1;      // Pulled-up pin level
  localparam int          RX_PERIOD   = 20;        // Mclk per rx segment
  localparam int          TX_LATENCY  = 10;        // Mark to segment valid
endpackage

// File: hdl/serial_mii_sync_port.sv
// Per-port serial receive and transmit paths, management pin and interrupt
module serial_mii_sync_port #(
  parameter int PORTS = 8
) (
  input  wire logic                      mclk_i,
  input  wire logic                      reset_i,
  input  wire logic                      srcsync_mode_i,
  input  wire logic                      mac_sync_i,
  input  wire logic                      tx_segment_marker_i,
  input  wire logic                      tx_source_clock_i,
  input  wire logic [PORTS-1:0]          tx_serial_in_i,
  input  wire logic [PORTS*10-1:0]       rx_segment_i,
  input  wire logic                      int_enable_i,
  input  wire logic                      status_change_i,
  input  wire logic                      mdio_i,
  input  wire logic                      mgmt_mdo_i,
  input  wire logic                      mgmt_drive_i,
  output logic      [PORTS*10-1:0]       tx_segment_o,
  output logic                           tx_segment_valid_o,
  output logic      [PORTS-1:0]          rx_serial_out_plain_o,
  output logic      [PORTS-1:0]          rx_serial_out_srcsync_o,
  output logic                           rx_segment_marker_o,
  output logic                           rx_source_clock_o,
  output logic                           rx_segment_take_o,
  output logic                           mdio_o,
  output logic                           mdio_oe_n_o,
  output logic                           mgmt_mdi_o,
  output logic                           mgmt_interrupt_n_o,
  output logic                           mgmt_interrupt_oe_n_o
);
  localparam int SW = PORTS + 3;
  localparam int SB = smii_pkg::SEG_BITS;
  // Filter rests at each pin's idle level, so no false edge after reset
  localparam logic [SW-1:0] PIN_IDLE = {smii_pkg::MDIO_IDLE, {(SW-1){1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic [SW-1:0] s3_r;
  logic [SW-1:0] filt_r;
  logic          tx_source_clock_prev_r;
  wire  [SW-1:0] pins_in = {mdio_i, tx_source_clock_i, tx_segment_marker_i,
                            tx_serial_in_i};

  // Three stages; a level counts only once stages two and three agree
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r         <= PIN_IDLE;
      s2_r         <= PIN_IDLE;
      s3_r         <= PIN_IDLE;
      filt_r       <= PIN_IDLE;
      tx_source_clock_prev_r <= 1'b0;
    end else begin
      s1_r         <= pins_in;
      s2_r         <= s1_r;
      s3_r         <= s2_r;
      filt_r       <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
      tx_source_clock_prev_r <= filt_r[PORTS+1];
    end
  end

  // Plain-mode pins share mclk and skip the filter: a bit lasts one cycle
  wire [PORTS-1:0] tx_bits    = srcsync_mode_i ? filt_r[PORTS-1:0]
                                               : tx_serial_in_i;
  wire             f_sync     = mac_sync_i;
  wire             f_txmark   = filt_r[PORTS];
  wire             f_tx_source_clock    = filt_r[PORTS+1];
  wire             f_mdio     = filt_r[PORTS+2];
  // Rises are seen only while the source clock stays at or below mclk/4
  wire             tx_source_clock_rise = f_tx_source_clock & ~tx_source_clock_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit deserialiser
  wire tx_step = srcsync_mode_i ? tx_source_clock_rise : 1'b1;
  wire tx_mark = srcsync_mode_i ? f_txmark : f_sync;
  logic [smii_pkg::CNT_W-1:0] tx_cnt_r;
  logic [smii_pkg::CNT_W-1:0] tx_cnt_nxt;
  logic                       tx_done;
  logic [PORTS*SB-1:0]        tx_sr_r;

  // Marker restarts the count; without any marker the counter idles
  always_comb begin
    tx_cnt_nxt = tx_cnt_r;
    tx_done    = 1'b0;
    if (tx_step) begin
      if (tx_mark) begin
        tx_cnt_nxt = smii_pkg::BIT_SECOND;
      end else if (tx_cnt_r == smii_pkg::BIT_LAST) begin
        tx_cnt_nxt = smii_pkg::BIT_FIRST;
        tx_done    = 1'b1;
      end else if (tx_cnt_r != smii_pkg::BIT_FIRST) begin
        tx_cnt_nxt = tx_cnt_r + smii_pkg::BIT_SECOND;
      end
    end
  end

  // Counter and valid strobe
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_cnt_r           <= smii_pkg::BIT_FIRST;
      tx_segment_valid_o <= 1'b0;
    end else begin
      tx_cnt_r           <= tx_cnt_nxt;
      tx_segment_valid_o <= tx_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side timing
  logic                       rx_source_clock_r;
  logic [smii_pkg::CNT_W-1:0] ss_cnt_r;
  wire  rx_step     = rx_source_clock_r;  // Next edge drops the clock: launch here
  wire  ss_load     = rx_step & (ss_cnt_r == smii_pkg::BIT_LAST);
  wire  [smii_pkg::CNT_W-1:0] ss_cnt_inc = ss_cnt_r + smii_pkg::BIT_SECOND;
  assign rx_source_clock_o = rx_source_clock_r;
  assign rx_segment_take_o = srcsync_mode_i ? ss_load : f_sync;

  // Divide-by-two receive clock and free-running segment count
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_source_clock_r             <= 1'b0;
      ss_cnt_r            <= smii_pkg::SS_CNT_RST;
      rx_segment_marker_o <= 1'b0;
    end else begin
      rx_source_clock_r <= ~rx_source_clock_r;
      if (rx_step) begin
        ss_cnt_r            <= ss_load ? smii_pkg::CNT_RST : ss_cnt_inc;
        rx_segment_marker_o <= ss_load;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port shift registers
  logic [PORTS*SB-1:0] rxp_sr_r;
  logic [PORTS*SB-1:0] rxs_sr_r;
  logic [PORTS-1:0]    seg_bit0;

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      wire [SB-1:0] seg = rx_segment_i[p*SB +: SB];
      assign seg_bit0[p] = seg[0];
      // Transmit bits enter at the top; first bit lands in bit zero
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          tx_sr_r[p*SB +: SB]      <= '0;
          tx_segment_o[p*SB +: SB] <= '0;
        end else begin
          if (tx_step) begin
            tx_sr_r[p*SB +: SB] <= {tx_bits[p], tx_sr_r[p*SB+1 +: SB-1]};
          end
          if (tx_done) begin
            tx_segment_o[p*SB +: SB] <=
              {tx_bits[p], tx_sr_r[p*SB+1 +: SB-1]};
          end
        end
      end
      // Plain receive is aligned to the MAC sync once per segment and shifts one bit each reference cycle
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          rxp_sr_r[p*SB +: SB]     <= '0;
          rx_serial_out_plain_o[p] <= 1'b0;
        end else if (f_sync) begin
          rx_serial_out_plain_o[p] <= seg[0];
          rxp_sr_r[p*SB +: SB]     <= {1'b0, seg[SB-1:1]};
        end else begin
          rx_serial_out_plain_o[p] <= rxp_sr_r[p*SB];
          rxp_sr_r[p*SB +: SB]     <= {1'b0, rxp_sr_r[p*SB+1 +: SB-1]};
        end
      end
      // Source-synchronous receive steps once per receive clock
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          rxs_sr_r[p*SB +: SB]       <= '0;
          rx_serial_out_srcsync_o[p] <= 1'b0;
        end else if (ss_load) begin
          rx_serial_out_srcsync_o[p] <= seg[0];
          rxs_sr_r[p*SB +: SB]       <= {1'b0, seg[SB-1:1]};
        end else if (rx_step) begin
          rx_serial_out_srcsync_o[p] <= rxs_sr_r[p*SB];
          rxs_sr_r[p*SB +: SB]       <= {1'b0, rxs_sr_r[p*SB+1 +: SB-1]};
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Management pin and open-drain interrupt
  assign mgmt_interrupt_n_o = 1'b0;  // Open drain: only ever pulls low

  // Pin launch registered to keep the line free of glitches
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      mdio_o                <= 1'b1;
      mdio_oe_n_o           <= 1'b1;
      mgmt_mdi_o            <= 1'b1;
      mgmt_interrupt_oe_n_o <= 1'b1;
    end else begin
      mdio_o                <= mgmt_mdo_i;
      mdio_oe_n_o           <= ~mgmt_drive_i;
      mgmt_mdi_o            <= f_mdio;
      mgmt_interrupt_oe_n_o <= ~(int_enable_i & status_change_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_plain_mark;
    !srcsync_mode_i && f_sync;
  endsequence
  sequence s_plain_quiet;
    !srcsync_mode_i && !f_sync;
  endsequence

  property p_rx_marker_period;
    $rose(rx_segment_marker_o) |-> ##20 $rose(rx_segment_marker_o);
  endproperty
  a_rx_marker_period: assert property (p_rx_marker_period)
    else $error("receive marker period wrong");

  property p_rx_clock_toggles;
    !$past(reset_i) |-> rx_source_clock_o != $past(rx_source_clock_o);
  endproperty
  a_rx_clock_toggles: assert property (p_rx_clock_toggles)
    else $error("receive clock stalled");

  property p_rx_launch_phase;
    $changed(rx_segment_marker_o) |-> !rx_source_clock_o;
  endproperty
  a_rx_launch_phase: assert property (p_rx_launch_phase)
    else $error("receive marker launched on wrong phase");

  property p_rx_plain_first;
    f_sync |=> rx_serial_out_plain_o == $past(seg_bit0);
  endproperty
  a_rx_plain_first: assert property (p_rx_plain_first)
    else $error("plain receive first bit wrong");

  property p_tx_plain_seg;
    s_plain_mark ##1 s_plain_quiet [*8] ##1 s_plain_quiet
      |=> tx_segment_valid_o;
  endproperty
  a_tx_plain_seg: assert property (p_tx_plain_seg)
    else $error("plain transmit segment not completed");

  property p_tx_valid_pulse;
    tx_segment_valid_o |=> !tx_segment_valid_o;
  endproperty
  a_tx_valid_pulse: assert property (p_tx_valid_pulse)
    else $error("transmit valid longer than one cycle");

  property p_tx_ss_step;
    srcsync_mode_i && $past(srcsync_mode_i) && $changed(tx_cnt_r)
      |-> $past(tx_source_clock_rise);
  endproperty
  a_tx_ss_step: assert property (p_tx_ss_step)
    else $error("transmit stepped without clock rise");

  property p_int_pull;
    !mgmt_interrupt_oe_n_o |-> $past(int_enable_i && status_change_i);
  endproperty
  a_int_pull: assert property (p_int_pull)
    else $error("interrupt pulled without cause");

  property p_mdio_drive;
    !reset_i && mgmt_drive_i |=> !mdio_oe_n_o && mdio_o == $past(mgmt_mdo_i);
  endproperty
  a_mdio_drive: assert property (p_mdio_drive)
    else $error("management pin not driven");
endmodule

// File: testbench/smii_mac_model.sv
// MAC-side model driving transmit pins, marker, sync and transmit clock
module smii_mac_model (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        mode_i,
  input  wire logic        run_i,
  input  wire logic [79:0] seg_i,
  output logic             sync_o,
  output logic             marker_o,
  output logic             tx_clk_o,
  output logic      [7:0]  data_o,
  output logic      [79:0] cur_o,
  output logic             load_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0]  ph_r;
  logic [3:0]  bit_r;
  logic        act_r;
  logic [79:0] src;
  ////////////////////////////////////////////////////////////////////////////
  // Tx clock at mclk/8: slow enough for the port's pin filter
  wire step = !mode_i || ph_r == 3'h0;
  // A segment once begun always runs to its tenth bit
  wire go = (run_i || bit_r != 4'h0) && step;
  assign src = (bit_r == 4'h0) ? seg_i : cur_o;
  ////////////////////////////////////////////////////////////////////////////
  // Marker with first bit, every ten steps; idle pins low
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      {ph_r, bit_r, act_r, sync_o, marker_o, tx_clk_o} <= '0;
      {data_o, cur_o, load_o} <= '0;
    end else begin
      ph_r <= ph_r + 3'h1;
      act_r <= go ? 1'b1 : (step ? 1'b0 : act_r);
      // Clock stands still between frames
      tx_clk_o <= mode_i && act_r && ph_r >= 3'h3 && ph_r != 3'h7;
      load_o <= go && bit_r == 4'h0;
      if (go) begin
        bit_r <= (bit_r == 4'h9) ? 4'h0 : bit_r + 4'h1;
        sync_o <= !mode_i && bit_r == 4'h0;
        marker_o <= mode_i && bit_r == 4'h0;
        for (int p = 0; p < 8; p++) data_o[p] <= src[p*10 + bit_r];
        if (bit_r == 4'h0) cur_o <= src;
      end else if (step) begin
        {sync_o, marker_o, data_o} <= '0;
      end
    end
  end
endmodule

// File: testbench/serial_mii_sync_port_bench.sv
// Self-checking bench of the serial port block against a MAC model
module serial_mii_sync_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_i = 1'b0;
  logic        reset_i, mode, run, int_en, stat, mdo, drv, mac_drv, mac_val;
  logic        sync, marker, tx_clk, load, tx_val, take, mark, rclk;
  logic        mdio_o, mdio_oe_n, mdi, int_n, int_oe_n, p_mdo, p_drv, p_int;
  logic        rst_d, rclk_d;
  logic [79:0] seg, rx_seg, cur, tx_cur, tx_seg;
  logic [7:0]  tx_data, rx_plain, rx_ss;
  logic [4:0]  mdio_h;
  logic [79:0] txq[$], rxq[$];
  integer      seed = 82;
  int          failures = 0;
  int          n_tests = 0;
  int          k = 10;
  // Pull-up holds the management line when nobody drives it
  wire mdio_line = !mdio_oe_n ? mdio_o : (mac_drv ? mac_val : 1'b1);
  always #12.5 mclk_i = ~mclk_i;  // Reference clock
  ////////////////////////////////////////////////////////////////////////////
  smii_mac_model u_mac (.mclk_i(mclk_i), .reset_i(reset_i), .mode_i(mode),
    .run_i(run), .seg_i(seg), .sync_o(sync), .marker_o(marker),
    .tx_clk_o(tx_clk), .data_o(tx_data), .cur_o(tx_cur), .load_o(load));
  serial_mii_sync_port u_dut (.mclk_i(mclk_i), .reset_i(reset_i),
    .srcsync_mode_i(mode), .mac_sync_i(sync), .tx_segment_marker_i(marker),
    .tx_source_clock_i(tx_clk), .tx_serial_in_i(tx_data),
    .rx_segment_i(rx_seg), .int_enable_i(int_en), .status_change_i(stat),
    .mdio_i(mdio_line), .mgmt_mdo_i(mdo), .mgmt_drive_i(drv),
    .tx_segment_o(tx_seg), .tx_segment_valid_o(tx_val),
    .rx_serial_out_plain_o(rx_plain), .rx_serial_out_srcsync_o(rx_ss),
    .rx_segment_marker_o(mark), .rx_source_clock_o(rclk),
    .rx_segment_take_o(take), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n),
    .mgmt_mdi_o(mdi), .mgmt_interrupt_n_o(int_n),
    .mgmt_interrupt_oe_n_o(int_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Driver: fresh random inputs each edge, receive segment only once taken; expectations noted in queues
  always @(posedge mclk_i) begin
    if (take === 1'b1) begin
      rxq.push_back(rx_seg);
      rx_seg <= 80'({$random(seed), $random(seed), $random(seed)});
    end
    if (load === 1'b1) txq.push_back(tx_cur);
    seg <= 80'({$random(seed), $random(seed), $random(seed)});
    {int_en, stat, mdo, drv, mac_drv, mac_val} <= 6'($random(seed));
    {p_mdo, p_drv, p_int, rst_d} <= {mdo, drv, int_en & stat, reset_i};
    // Mixed fill in reset: the pin filter samples nothing while held
    mdio_h <= reset_i ? 5'h15 : {mdio_h[3:0], mdio_line};
  end
  ////////////////////////////////////////////////////////////////////////////
  // Watcher: outputs checked mid-cycle, once settled
  always @(negedge mclk_i) begin
    if (reset_i) begin
      k = 10;
      rxq.delete();
      txq.delete();
    end else begin
      if (tx_val === 1'b1)
        check(tx_seg, txq.size() ? txq.pop_front() : ~tx_seg);
      if (k == -1) begin
        cur = rxq.pop_front();
        k = 0;
      end
      if (k < 10 && (!mode || rclk === 1'b0)) begin
        for (int p = 0; p < 8; p++)
          check(mode ? rx_ss[p] : rx_plain[p], cur[p*10 + k]);
        if (mode) check(mark, k == 0);
        k++;
      end
      if (take === 1'b1) k = -1;
      if (!rst_d) begin
        check({mdio_o, mdio_oe_n}, {p_mdo, ~p_drv});
        check({int_n, int_oe_n}, {1'b0, ~p_int});
        if (&mdio_h || ~|mdio_h) check(mdi, mdio_h[0]);
        check(rclk, !rclk_d);
      end
      rclk_d = rclk;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: plain variant, then reset, then source-synchronous
  initial begin
    {mode, run, int_en, stat, mdo, drv, mac_drv, mac_val} = '0;
    {seg, rx_seg, mdio_h} = '0;
    reset_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    run <= 1'b1;
    repeat (600) @(posedge mclk_i);
    run <= 1'b0;
    repeat (40) @(posedge mclk_i);
    check(80'(txq.size()), 80'h0);
    $display("plain variant test done");
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    {mode, reset_i, run} <= 3'b101;
    repeat (1200) @(posedge mclk_i);
    run <= 1'b0;
    repeat (150) @(posedge mclk_i);
    check(80'(txq.size()), 80'h0);
    $display("source-synchronous variant test done");
    print_verdict();
  end
  // Watchdog well beyond the two phases of about 2000 cycles
  initial begin
    #100us;
    failures++;
    print_verdict();
  end
endmodule
